// [logic/cca_pkg.sv]
`default_nettype none
package cca_pkg;

   // ----------------------------------------
   // register offsets and reset values
   // ----------------------------------------
   localparam logic [7:0] ADDR_EXCL     = 8'h36;
   localparam logic [7:0] ADDR_CARRIER  = 8'h37;
   localparam logic [7:0] ADDR_TIMEOUT  = 8'h38;
   localparam logic [7:0] ADDR_CTRL     = 8'h39;
   localparam logic [7:0] EXCL_RST      = 8'hFE;
   localparam logic [7:0] CARRIER_RST   = 8'h5C;
   localparam logic [7:0] TIMEOUT_RST   = 8'hFF;
   localparam logic [7:0] CTRL_RST      = 8'h00;

   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int BIT_STOP  = 7;
   localparam int BIT_IDLE  = 6;
   localparam int BIT_CONT  = 5;
   localparam int BIT_EXEC  = 4;
   localparam int BIT_FAST  = 3;
   localparam int BIT_ABORT = 2;

   // ----------------------------------------
   // result codes
   // ----------------------------------------
   localparam logic [1:0] RES_NONE    = 2'h0;
   localparam logic [1:0] RES_CARRIER = 2'h1;
   localparam logic [1:0] RES_IDLE    = 2'h2;
   localparam logic [1:0] RES_ACQ     = 2'h3;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int TIMEOUT_UNIT_NS = 128000;
   localparam int WAIT_UNIT_NS    = 16000;
   localparam int TIMEOUT_UNIT_CYC = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;
   localparam int WAIT_UNIT_CYC    = WAIT_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {ST_OFF, ST_ACQ, ST_IDLE_WAIT} cca_state_t;

endpackage
`default_nettype wire

// [logic/cca_top.sv]
// Behaviour
// - samples above the exclusion level are kept out of the average
// - average above carrier level gives the carrier-found result
// - timeout count of zero disables forced termination
// - one timeout unit is 128 microseconds
// - forced termination acts only while idle detection is enabled
// - continuous enable repeats the assessment until stopped or forced termination
// - continuous assessment ends when software writes the stop bit or on forced termination
// - idle detection enable makes the block look for a long quiet period
// - execute bit starts one run and clears itself on completion
// - fast check runs on receive start and requests sleep if no carrier
// - result codes: 00 none, 01 carrier, 10 judging idle, 11 acquiring
// - result holds after a verdict, never cleared by the block itself
// - clearing the completion interrupt flag clears the result, except during the first block of a run and during the idle wait
// - each completion raises the completion event
// - idle period is averaging period plus wait count times 16 microseconds
`timescale 1ns/100ps
`default_nettype none
module cca_top (
   // clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       RESET_N,
   // register port
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       REG_WR,
   output logic      [7:0] REG_RDATA,
   // energy samples
   input  wire logic [7:0] ENERGY_VALUE,
   input  wire logic       ENERGY_VALID,
   input  wire logic [2:0] ENERGY_AVERAGE_COUNT,
   input  wire logic [9:0] IDLE_WAIT_COUNT,
   // radio and interrupt side
   input  wire logic       RX_ACTIVE,
   input  wire logic       INT_GROUP3_CLEAR,
   output logic            ASSESS_DONE,
   output logic            RADIO_OFF_REQ,
   output logic            PACKET_DISCARD,
   output logic            SLEEP_REQ
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   cca_pkg::cca_state_t state_r, state_nxt;
   logic [7:0]  excl_r, excl_nxt, lvl_r, lvl_nxt, tmo_r, tmo_nxt;
   logic        stop_r, stop_nxt, idle_en_r, idle_en_nxt, cont_r, cont_nxt;
   logic        exec_r, exec_nxt, fast_r, fast_nxt, abort_en_r, abort_en_nxt;
   logic [1:0]  result_r, result_nxt;
   logic [14:0] sum_r, sum_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [10:0] tmo_pre_r, tmo_pre_nxt;
   logic [7:0]  tmo_cnt_r, tmo_cnt_nxt;
   logic [7:0]  wait_pre_r, wait_pre_nxt;
   logic [9:0]  wait_cnt_r, wait_cnt_nxt;
   logic        fast_run_r, fast_run_nxt, rx_d_r;
   logic        done_nxt, off_nxt, sleep_nxt;
   logic [7:0]  rdata_nxt;

   logic        wr_ctrl, sample_ok, block_done, abort, verdict, stop_act;
   logic        run_req, carrier;
   logic [14:0] sum_add;
   logic [7:0]  avg_new, need;
   logic [1:0]  code;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      excl_nxt     = excl_r;
      lvl_nxt      = lvl_r;
      tmo_nxt      = tmo_r;
      stop_nxt     = stop_r;
      idle_en_nxt  = idle_en_r;
      cont_nxt     = cont_r;
      exec_nxt     = exec_r;
      fast_nxt     = fast_r;
      abort_en_nxt = abort_en_r;
      result_nxt   = result_r;
      state_nxt    = state_r;
      sum_nxt      = sum_r;
      cnt_nxt      = cnt_r;
      tmo_pre_nxt  = tmo_pre_r;
      tmo_cnt_nxt  = tmo_cnt_r;
      wait_pre_nxt = wait_pre_r;
      wait_cnt_nxt = wait_cnt_r;
      fast_run_nxt = fast_run_r;
      done_nxt     = 1'b0;
      off_nxt      = 1'b0;
      sleep_nxt    = 1'b0;
      verdict      = 1'b0;
      code         = cca_pkg::RES_NONE;

      wr_ctrl = REG_WR && (REG_ADDR == cca_pkg::ADDR_CTRL);
      if (REG_WR && REG_ADDR == cca_pkg::ADDR_EXCL) begin
         excl_nxt = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == cca_pkg::ADDR_CARRIER) begin
         lvl_nxt = REG_WDATA;
      end
      if (REG_WR && REG_ADDR == cca_pkg::ADDR_TIMEOUT) begin
         tmo_nxt = REG_WDATA;
      end
      if (wr_ctrl) begin
         stop_nxt     = REG_WDATA[cca_pkg::BIT_STOP];
         idle_en_nxt  = REG_WDATA[cca_pkg::BIT_IDLE];
         cont_nxt     = REG_WDATA[cca_pkg::BIT_CONT];
         exec_nxt     = REG_WDATA[cca_pkg::BIT_EXEC];
         fast_nxt     = REG_WDATA[cca_pkg::BIT_FAST];
         abort_en_nxt = REG_WDATA[cca_pkg::BIT_ABORT];
         result_nxt   = REG_WDATA[1:0];
      end
      if (INT_GROUP3_CLEAR) begin
         result_nxt = cca_pkg::RES_NONE;
      end

      // sample averaging; excluded samples never reach the sum
      sample_ok  = ENERGY_VALID && !(ENERGY_VALUE > excl_r);
      need       = 8'(8'h01 << ENERGY_AVERAGE_COUNT);
      sum_add    = sum_r + {7'h00, ENERGY_VALUE};
      avg_new    = 8'(sum_add >> ENERGY_AVERAGE_COUNT);
      block_done = (state_r != cca_pkg::ST_OFF) && sample_ok && (cnt_r + 8'h01 == need);
      carrier    = block_done && (avg_new > lvl_r);
      if (state_r != cca_pkg::ST_OFF && sample_ok) begin
         sum_nxt = block_done ? 15'h0000 : sum_add;
         cnt_nxt = block_done ? 8'h00 : cnt_r + 8'h01;
      end

      // 128 us timeout ticks
      if (state_r != cca_pkg::ST_OFF) begin
         if (tmo_pre_r == 11'(cca_pkg::TIMEOUT_UNIT_CYC - 1)) begin
            tmo_pre_nxt = 11'h000;
            tmo_cnt_nxt = tmo_cnt_r + 8'h01;
         end else begin
            tmo_pre_nxt = tmo_pre_r + 11'h001;
         end
      end
      abort = (state_r != cca_pkg::ST_OFF) && abort_en_r && idle_en_r
              && (tmo_r != 8'h00) && (tmo_cnt_r == tmo_r);

      run_req = exec_nxt || cont_nxt || (fast_r && RX_ACTIVE && !rx_d_r);

      unique case (state_r)
         cca_pkg::ST_OFF: begin
            if (run_req) begin
               state_nxt    = cca_pkg::ST_ACQ;
               result_nxt   = cca_pkg::RES_ACQ;
               fast_run_nxt = !exec_nxt && !cont_nxt;
               sum_nxt      = 15'h0000;
               cnt_nxt      = 8'h00;
               tmo_pre_nxt  = 11'h000;
               tmo_cnt_nxt  = 8'h00;
            end
         end
         cca_pkg::ST_ACQ: begin
            // first block: no clear or write may fake a verdict
            if (result_r == cca_pkg::RES_ACQ) begin
               result_nxt = cca_pkg::RES_ACQ;
            end
            if (carrier) begin
               verdict = 1'b1;
               code    = cca_pkg::RES_CARRIER;
            end else if (block_done && idle_en_r) begin
               state_nxt    = cca_pkg::ST_IDLE_WAIT;
               result_nxt   = cca_pkg::RES_IDLE;
               wait_pre_nxt = 8'h00;
               wait_cnt_nxt = 10'h000;
            end else if (block_done) begin
               verdict = 1'b1;
            end
         end
         cca_pkg::ST_IDLE_WAIT: begin
            result_nxt = cca_pkg::RES_IDLE;
            if (wait_pre_r == 8'(cca_pkg::WAIT_UNIT_CYC - 1)) begin
               wait_pre_nxt = 8'h00;
               wait_cnt_nxt = wait_cnt_r + 10'h001;
            end else begin
               wait_pre_nxt = wait_pre_r + 8'h01;
            end
            if (carrier) begin
               verdict = 1'b1;
               code    = cca_pkg::RES_CARRIER;
            end else if (wait_cnt_r >= IDLE_WAIT_COUNT) begin
               verdict = 1'b1;
            end
         end
      endcase

      if (verdict) begin
         result_nxt = code;
         done_nxt   = 1'b1;
         sleep_nxt  = fast_run_r && (code == cca_pkg::RES_NONE);
         if (cont_r) begin
            state_nxt   = cca_pkg::ST_ACQ;
            tmo_pre_nxt = 11'h000;
            tmo_cnt_nxt = 8'h00;
         end else begin
            state_nxt = cca_pkg::ST_OFF;
            exec_nxt  = 1'b0;
         end
      end

      stop_act = stop_r && cont_r;
      if (stop_act) begin
         cont_nxt  = 1'b0;
         stop_nxt  = 1'b0;
         state_nxt = cca_pkg::ST_OFF;
      end
      if (abort) begin
         state_nxt = cca_pkg::ST_OFF;
         exec_nxt  = 1'b0;
         cont_nxt  = 1'b0;
         off_nxt   = 1'b1;
         done_nxt  = 1'b1;
      end

      unique case (REG_ADDR)
         cca_pkg::ADDR_EXCL:    rdata_nxt = excl_r;
         cca_pkg::ADDR_CARRIER: rdata_nxt = lvl_r;
         cca_pkg::ADDR_TIMEOUT: rdata_nxt = tmo_r;
         cca_pkg::ADDR_CTRL:    rdata_nxt = {stop_r, idle_en_r, cont_r, exec_r,
                                             fast_r, abort_en_r, result_r};
         default:               rdata_nxt = 8'h00;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         state_r        <= cca_pkg::ST_OFF;
         excl_r         <= cca_pkg::EXCL_RST;
         lvl_r          <= cca_pkg::CARRIER_RST;
         tmo_r          <= cca_pkg::TIMEOUT_RST;
         {stop_r, idle_en_r, cont_r, exec_r, fast_r, abort_en_r, result_r}
                        <= cca_pkg::CTRL_RST;
         sum_r          <= 15'h0000;
         cnt_r          <= 8'h00;
         tmo_pre_r      <= 11'h000;
         tmo_cnt_r      <= 8'h00;
         wait_pre_r     <= 8'h00;
         wait_cnt_r     <= 10'h000;
         fast_run_r     <= 1'b0;
         rx_d_r         <= 1'b0;
         ASSESS_DONE    <= 1'b0;
         RADIO_OFF_REQ  <= 1'b0;
         PACKET_DISCARD <= 1'b0;
         SLEEP_REQ      <= 1'b0;
         REG_RDATA      <= 8'h00;
      end else begin
         state_r        <= state_nxt;
         excl_r         <= excl_nxt;
         lvl_r          <= lvl_nxt;
         tmo_r          <= tmo_nxt;
         stop_r         <= stop_nxt;
         idle_en_r      <= idle_en_nxt;
         cont_r         <= cont_nxt;
         exec_r         <= exec_nxt;
         fast_r         <= fast_nxt;
         abort_en_r     <= abort_en_nxt;
         result_r       <= result_nxt;
         sum_r          <= sum_nxt;
         cnt_r          <= cnt_nxt;
         tmo_pre_r      <= tmo_pre_nxt;
         tmo_cnt_r      <= tmo_cnt_nxt;
         wait_pre_r     <= wait_pre_nxt;
         wait_cnt_r     <= wait_cnt_nxt;
         fast_run_r     <= fast_run_nxt;
         rx_d_r         <= RX_ACTIVE;
         ASSESS_DONE    <= done_nxt;
         RADIO_OFF_REQ  <= off_nxt;
         PACKET_DISCARD <= off_nxt;
         SLEEP_REQ      <= sleep_nxt;
         REG_RDATA      <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   excl_skip_a: assert property (state_r == cca_pkg::ST_ACQ && ENERGY_VALID
      && ENERGY_VALUE > excl_r |=> cnt_r == $past(cnt_r) || state_r == cca_pkg::ST_OFF)
      else $error("excluded sample counted");
   acq_code_a: assert property ($past(state_r) == cca_pkg::ST_OFF
      && state_r == cca_pkg::ST_ACQ |-> result_r == cca_pkg::RES_ACQ)
      else $error("start not showing acquiring");
   carrier_set_a: assert property (carrier && !abort && !stop_act
      |=> result_r == cca_pkg::RES_CARRIER && ASSESS_DONE)
      else $error("carrier not reported");
   tmo_zero_a: assert property (tmo_r == 8'h00 |=> !RADIO_OFF_REQ)
      else $error("abort with zero timeout");
   tmo_unit_a: assert property (tmo_cnt_r != $past(tmo_cnt_r) && tmo_cnt_r != 8'h00
      |-> $past(tmo_pre_r) == 11'(cca_pkg::TIMEOUT_UNIT_CYC - 1))
      else $error("timeout unit not 128 us");
   abort_out_a: assert property (abort |=> state_r == cca_pkg::ST_OFF
      && RADIO_OFF_REQ && PACKET_DISCARD ##1 !RADIO_OFF_REQ)
      else $error("forced termination incomplete");
   abort_gate_a: assert property (!idle_en_r || !abort_en_r |=> !RADIO_OFF_REQ)
      else $error("abort without enables");
   cont_loop_a: assert property (verdict && cont_r && !stop_act && !abort
      |=> state_r == cca_pkg::ST_ACQ)
      else $error("continuous run stopped");
   stop_cont_a: assert property (stop_act && !wr_ctrl
      |=> !cont_r && state_r == cca_pkg::ST_OFF)
      else $error("stop ignored");
   exec_clr_a: assert property (verdict && !cont_r && !wr_ctrl
      |=> !exec_r && state_r == cca_pkg::ST_OFF)
      else $error("execute bit not cleared");
   fast_sleep_a: assert property (verdict && fast_run_r
      && code == cca_pkg::RES_NONE && !abort |=> SLEEP_REQ)
      else $error("fast check sleep missing");
   hold_res_a: assert property (state_r == cca_pkg::ST_OFF && !wr_ctrl
      && !INT_GROUP3_CLEAR && !run_req |=> $stable(result_r))
      else $error("result changed by itself");
   clear_res_a: assert property (state_r == cca_pkg::ST_OFF && INT_GROUP3_CLEAR
      && !wr_ctrl && !run_req |=> result_r == cca_pkg::RES_NONE)
      else $error("result not cleared");
   idle_wait_a: assert property (state_r == cca_pkg::ST_IDLE_WAIT
      |-> wait_cnt_r <= IDLE_WAIT_COUNT)
      else $error("idle wait overran");

   carrier_c: cover property (carrier ##1 ASSESS_DONE);
   idle_c:    cover property (state_r == cca_pkg::ST_IDLE_WAIT ##[1:1000] verdict);
   abort_c:   cover property (abort);
   sleep_c:   cover property (SLEEP_REQ);

endmodule
`default_nettype wire

// [tb/cca_energy_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cca_energy_model (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // burst request
   input  wire logic       go,
   input  wire logic [7:0] level,
   input  wire logic [7:0] count,
   input  wire logic [3:0] gap,
   output logic            busy,
   // sample stream
   output logic [7:0]      energy_value,
   output logic            energy_valid
);
   logic [7:0] lvl_r;
   logic [7:0] left_r;
   logic [3:0] gap_r;
   logic [3:0] wait_r;

   // ----------------------------------------
   // burst of equal samples, optional gaps
   // ----------------------------------------
   // value line toggles outside strobes so stale data never looks fresh
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
         energy_valid <= 1'b0;
         energy_value <= 8'h00;
         left_r <= 8'h00;
         wait_r <= 4'h0;
      end else if (go) begin
         busy <= 1'b1;
         lvl_r <= level;
         left_r <= count;
         gap_r <= gap;
         wait_r <= 4'h0;
         energy_valid <= 1'b0;
         energy_value <= ~energy_value;
      end else if (busy && left_r != 8'h00 && wait_r == 4'h0) begin
         energy_valid <= 1'b1;
         energy_value <= lvl_r;
         left_r <= left_r - 8'h01;
         wait_r <= gap_r;
      end else begin
         busy <= busy && left_r != 8'h00;
         wait_r <= (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
         energy_valid <= 1'b0;
         energy_value <= ~energy_value;
      end
   end
endmodule
`default_nettype wire

// [tb/cca_top_test.sv]
`timescale 1ns/100ps
`default_nettype none
module cca_top_test;
   logic       ref_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] energy_value;
   logic       energy_valid;
   logic [2:0] avg_count = 3'h3;
   logic [9:0] idle_wait = 10'h002;
   logic       rx_active = 1'b0;
   logic       int_clear = 1'b0;
   logic       assess_done, radio_off, pkt_discard, sleep_req;
   logic       go = 1'b0;
   logic [7:0] lvl = 8'h00;
   logic [7:0] cnt = 8'h00;
   logic [3:0] gap = 4'h0;
   logic       busy;
   logic [2:0] ac [4] = '{3'h3, 3'h3, 3'h0, 3'h7};
   logic [7:0] sv [4] = '{8'h40, 8'h80, 8'h50, 8'h10};
   logic [7:0] sn [4] = '{8'h08, 8'h08, 8'h01, 8'h80};
   logic [7:0] sr [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
   int         miscompares = 0;
   int         n_compared = 0;
   int         n_done = 0;
   int         n_off = 0;
   int         n_sleep = 0;
   int         nd = 0;
   int         cyc = 0;

   always #50 ref_clk = ~ref_clk;

   cca_top dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RDATA(reg_rdata),
      .ENERGY_VALUE(energy_value), .ENERGY_VALID(energy_valid),
      .ENERGY_AVERAGE_COUNT(avg_count), .IDLE_WAIT_COUNT(idle_wait),
      .RX_ACTIVE(rx_active), .INT_GROUP3_CLEAR(int_clear), .ASSESS_DONE(assess_done),
      .RADIO_OFF_REQ(radio_off), .PACKET_DISCARD(pkt_discard), .SLEEP_REQ(sleep_req));

   cca_energy_model model (.ref_clk(ref_clk), .reset_n(reset_n), .go(go), .level(lvl),
      .count(cnt), .gap(gap), .busy(busy), .energy_value(energy_value),
      .energy_valid(energy_valid));

   // ----------------------------------------
   // reporting and bus tasks
   // ----------------------------------------
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(reg_rdata, exp);
   endtask

   task automatic send(input logic [7:0] v, input logic [7:0] n, input logic [3:0] g);
      int k;
      @(posedge ref_clk);
      lvl <= v;
      cnt <= n;
      gap <= g;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
      for (k = 0; k < 4000 && (k == 0 || busy); k++) @(negedge ref_clk);
      repeat (3) @(negedge ref_clk);
   endtask

   // pulse counters and watchdog
   always @(posedge ref_clk) begin
      cyc++;
      if (assess_done === 1'b1) n_done++;
      if (radio_off === 1'b1) n_off++;
      if (sleep_req === 1'b1) n_sleep++;
      if (radio_off !== 1'b0 || pkt_discard !== 1'b0) chk(8'(pkt_discard), 8'(radio_off));
      if (cyc == 12000) begin
         miscompares++;
         test_done;
      end
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h36, 8'hFE);
      rd(8'h37, 8'h5C);
      rd(8'h38, 8'hFF);
      rd(8'h39, 8'h00);
      wr(8'h3A, 8'h55);
      rd(8'h3A, 8'h00);
      wr(8'h36, 8'h80);
      wr(8'h37, 8'h40);
      rd(8'h36, 8'h80);
      rd(8'h37, 8'h40);
      wr(8'h39, 8'h10);
      rd(8'h39, 8'h13);
      send(8'h81, 8'h03, 4'h2);
      rd(8'h39, 8'h13);
      @(posedge ref_clk) int_clear <= 1'b1;
      @(posedge ref_clk) int_clear <= 1'b0;
      rd(8'h39, 8'h13);
      chk(8'(n_done), 8'(nd));
      send(8'h41, 8'h08, 4'h0);
      nd++;
      chk(8'(n_done), 8'(nd));
      rd(8'h39, 8'h01);
      repeat (40) @(negedge ref_clk);
      rd(8'h39, 8'h01);
      @(posedge ref_clk) int_clear <= 1'b1;
      @(posedge ref_clk) int_clear <= 1'b0;
      rd(8'h39, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk) avg_count <= ac[i];
         wr(8'h39, 8'h10);
         send(sv[i], sn[i], 4'h1);
         nd++;
         rd(8'h39, sr[i]);
         chk(8'(n_done), 8'(nd));
      end
      @(posedge ref_clk) avg_count <= 3'h3;
      wr(8'h39, 8'h20);
      send(8'h10, 8'h08, 4'h0);
      send(8'h10, 8'h08, 4'h3);
      nd += 2;
      chk(8'(n_done), 8'(nd));
      wr(8'h39, 8'hA0);
      rd(8'h39, 8'h00);
      send(8'h50, 8'h08, 4'h0);
      chk(8'(n_done), 8'(nd));
      wr(8'h39, 8'h50);
      send(8'h10, 8'h08, 4'h0);
      rd(8'h39, 8'h52);
      repeat (200) @(negedge ref_clk);
      chk(8'(n_done), 8'(nd));
      repeat (250) @(negedge ref_clk);
      nd++;
      chk(8'(n_done), 8'(nd));
      rd(8'h39, 8'h40);
      wr(8'h38, 8'h01);
      wr(8'h39, 8'h54);
      repeat (1200) @(negedge ref_clk);
      chk(8'(n_off), 8'h00);
      repeat (200) @(negedge ref_clk);
      nd++;
      chk(8'(n_off), 8'h01);
      chk(8'(n_done), 8'(nd));
      wr(8'h39, 8'h14);
      repeat (1500) @(negedge ref_clk);
      chk(8'(n_off), 8'h01);
      send(8'h50, 8'h08, 4'h0);
      wr(8'h38, 8'h00);
      wr(8'h39, 8'h54);
      repeat (1500) @(negedge ref_clk);
      chk(8'(n_off), 8'h01);
      send(8'h50, 8'h08, 4'h0);
      nd += 2;
      chk(8'(n_done), 8'(nd));
      wr(8'h39, 8'h08);
      @(posedge ref_clk) rx_active <= 1'b1;
      send(8'h10, 8'h08, 4'h0);
      chk(8'(n_sleep), 8'h01);
      @(posedge ref_clk) rx_active <= 1'b0;
      @(posedge ref_clk) rx_active <= 1'b1;
      send(8'h50, 8'h08, 4'h0);
      nd += 2;
      chk(8'(n_sleep), 8'h01);
      chk(8'(n_done), 8'(nd));
      test_done;
   end
endmodule
`default_nettype wire
